// *** pkg/asl_pkg.sv ***
package asl_pkg;

	// Operation select codes presented by the core's decoder
	typedef enum logic [4:0] {
		ASL_NOP = 5'h00,
		ASL_ROT_L = 5'h01,
		ASL_ROT_LC = 5'h02,
		ASL_ROT_R = 5'h03,
		ASL_ROT_RC = 5'h04,
		ASL_SHL1 = 5'h05,
		ASL_SHL2 = 5'h06,
		ASL_SHL4 = 5'h07,
		ASL_SRL = 5'h08,
		ASL_SHRA1 = 5'h09,
		ASL_SHRA2 = 5'h0a,
		ASL_SHRA4 = 5'h0b,
		ASL_SUB = 5'h0c,
		ASL_SUBC = 5'h0d,
		ASL_BSWAP = 5'h0e,
		ASL_NSWAP = 5'h0f,
		ASL_XOR = 5'h10,
		ASL_XORC = 5'h11
	} asl_op_t;

	// Opcode patterns: top nibble of source-form instructions (f = bit 15)
	localparam logic [2:0] ASL_SUB_NIB = 3'h5;
	localparam logic [2:0] ASL_SUBC_NIB = 3'h7;
	localparam logic [2:0] ASL_XOR_NIB = 3'h3;
	localparam logic [7:0] ASL_ACC_BYTE = 8'h8a;
	localparam logic [7:0] ASL_NSWAP_LO = 8'h7a;
	localparam logic [7:0] ASL_BSWAP_LO = 8'h8a;
	localparam logic [7:0] ASL_XORC_HI = 8'hba;
	localparam logic [3:0] ASL_XORC_LO = 4'ha;

	// Reset values
	localparam logic [15:0] ASL_ACC_RST = 16'h0000;
	localparam logic ASL_FLAG_RST = 1'b0;

endpackage

// *** src/asl_src_mux.sv ***
`timescale 1ns/1ns
// Forms the 16-bit source: byte sources take the high byte from prefix
module asl_src_mux
	import asl_pkg::*;
(
	input wire logic [15:0] src_data, // Raw source value
	input wire logic src_is_byte, // Source is an 8-bit value
	input wire logic [7:0] high_byte_prefix_reg, // Prefix high byte
	output logic [15:0] src_word // Widened source
);

	// [RL15] prefix high byte
	assign src_word = src_is_byte ?
		{high_byte_prefix_reg, src_data[7:0]} : src_data;

endmodule

// *** src/asl_unit.sv ***
`timescale 1ns/1ns
// Behaviour
// [RL1] Rotate left wraps bit 15 to bit 0
// [RL2] Carry rotate left swaps carry through ends
// [RL3] Left rotates set sign; carry form adds C,Z
// [RL4] Rotate right wraps bit 0 to bit 15
// [RL5] Carry rotate right swaps carry through ends
// [RL6] Right rotates set sign; carry form adds C,Z
// [RL7] Left shifts by 1,2,4, top into carry
// [RL8] Logical right shift inserts zero at top
// [RL9] Arithmetic right shifts replicate the top bit
// [RL10] Bit leaving bottom goes into carry
// [RL11] Two and four place right shifts
// [RL12] Right shifts set C,Z; sign for logical only
// [RL13] Subtract source, flags C,S,Z,OV
// [RL14] Subtract with borrow also subtracts carry
// [RL15] Byte sources take prefix high byte
// [RL16] Source must not be working register
// [RL17] Byte swap updates only sign
// [RL18] Nibble swap within bytes, sign only
// [RL19] Xor with source updates sign, zero
// [RL20] Carry xor selected bit, nothing else
// [RL21] Sign is bit 15, zero on zero
module asl_unit
	import asl_pkg::*;
(
	input wire logic mclk, // Core clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic op_valid, // Execute op this cycle
	input wire asl_op_t op_sel, // Decoded operation
	input wire logic [3:0] bit_sel, // Bit index for carry xor
	input wire logic [15:0] src_data, // Source operand
	input wire logic src_is_byte, // Source given as 8 bits
	input wire logic [7:0] high_byte_prefix_reg, // Prefix high byte
	input wire logic acc_load, // Load working register
	input wire logic [15:0] acc_load_data, // Value to load
	output logic [15:0] acc_q, // Working register
	output logic carry_q, // Carry flag
	output logic sign_q, // Sign flag
	output logic zero_q, // Zero flag
	output logic signed_range_flag_q // Overflow flag
);

	logic [15:0] src_word;
	logic [15:0] res;
	logic c_new;
	logic upd_c;
	logic upd_s;
	logic upd_z;
	logic upd_rng;
	logic rng_new;
	logic wr_acc;
	logic [16:0] diff;
	logic [15:0] acc_d;
	logic carry_d;
	logic sign_d;
	logic zero_d;
	logic rng_d;

	asl_src_mux u_src
	(
		.src_data(src_data),
		.src_is_byte(src_is_byte),
		.high_byte_prefix_reg(high_byte_prefix_reg),
		.src_word(src_word)
	);

	// Subtraction: bit 16 of the 17-bit difference is the borrow
	// [RL13] subtract flags
	// [RL14] borrow included
	assign diff = {1'b0, acc_q} - {1'b0, src_word}
		- {16'h0000, (op_sel == ASL_SUBC) & carry_q};
	assign rng_new = (acc_q[15] ^ src_word[15]) & (acc_q[15] ^ diff[15]);

	// Result and carry selection per operation
	always_comb
	begin
		res = acc_q;
		c_new = carry_q;
		upd_c = 1'b0;
		upd_s = 1'b0;
		upd_z = 1'b0;
		upd_rng = 1'b0;
		wr_acc = 1'b1;
		case (op_sel)
			// [RL1] rotate left
			ASL_ROT_L:
			begin
				res = {acc_q[14:0], acc_q[15]};
				upd_s = 1'b1;
			end
			// [RL2] carry left rotate
			// [RL3] flag set
			ASL_ROT_LC:
			begin
				res = {acc_q[14:0], carry_q};
				c_new = acc_q[15];
				upd_c = 1'b1;
				upd_s = 1'b1;
				upd_z = 1'b1;
			end
			// [RL4] rotate right
			// [RL6] sign only
			ASL_ROT_R:
			begin
				res = {acc_q[0], acc_q[15:1]};
				upd_s = 1'b1;
			end
			// [RL5] carry right rotate
			ASL_ROT_RC:
			begin
				res = {carry_q, acc_q[15:1]};
				c_new = acc_q[0];
				upd_c = 1'b1;
				upd_s = 1'b1;
				upd_z = 1'b1;
			end
			// [RL7] left shifts
			ASL_SHL1:
			begin
				res = {acc_q[14:0], 1'b0};
				c_new = acc_q[15];
				upd_c = 1'b1;
				upd_s = 1'b1;
				upd_z = 1'b1;
			end
			ASL_SHL2:
			begin
				res = {acc_q[13:0], 2'b00};
				c_new = acc_q[14];
				upd_c = 1'b1;
				upd_s = 1'b1;
				upd_z = 1'b1;
			end
			ASL_SHL4:
			begin
				res = {acc_q[11:0], 4'h0};
				c_new = acc_q[12];
				upd_c = 1'b1;
				upd_s = 1'b1;
				upd_z = 1'b1;
			end
			// [RL8] logical right
			// [RL10] bottom to carry
			ASL_SRL:
			begin
				res = {1'b0, acc_q[15:1]};
				c_new = acc_q[0];
				upd_c = 1'b1;
				upd_s = 1'b1;
				upd_z = 1'b1;
			end
			// [RL9] sign replication
			// [RL12] sign kept
			ASL_SHRA1:
			begin
				res = {acc_q[15], acc_q[15:1]};
				c_new = acc_q[0];
				upd_c = 1'b1;
				upd_z = 1'b1;
			end
			// [RL11] multi-place right
			ASL_SHRA2:
			begin
				res = {{2{acc_q[15]}}, acc_q[15:2]};
				c_new = acc_q[1];
				upd_c = 1'b1;
				upd_z = 1'b1;
			end
			ASL_SHRA4:
			begin
				res = {{4{acc_q[15]}}, acc_q[15:4]};
				c_new = acc_q[3];
				upd_c = 1'b1;
				upd_z = 1'b1;
			end
			// Source must differ from the working register; the decoder
			// guarantees it, so no forwarding of this cycle's result.
			ASL_SUB, ASL_SUBC:
			begin
				res = diff[15:0];
				c_new = diff[16];
				upd_c = 1'b1;
				upd_s = 1'b1;
				upd_z = 1'b1;
				upd_rng = 1'b1;
			end
			// [RL17] byte swap
			ASL_BSWAP:
			begin
				res = {acc_q[7:0], acc_q[15:8]};
				upd_s = 1'b1;
			end
			// [RL18] nibble swap
			ASL_NSWAP:
			begin
				res = {acc_q[11:8], acc_q[15:12], acc_q[3:0], acc_q[7:4]};
				upd_s = 1'b1;
			end
			// [RL19] xor source
			ASL_XOR:
			begin
				res = acc_q ^ src_word;
				upd_s = 1'b1;
				upd_z = 1'b1;
			end
			// [RL20] carry xor bit
			ASL_XORC:
			begin
				c_new = carry_q ^ acc_q[bit_sel];
				upd_c = 1'b1;
				wr_acc = 1'b0;
			end
			default:
			begin
				wr_acc = 1'b0;
			end
		endcase
	end

	// Next-state values; a direct load wins only when no executing op writes the working register
	// [RL21] sign and zero
	assign acc_d = (op_valid & wr_acc) ? res :
		(acc_load ? acc_load_data : acc_q);
	assign carry_d = (op_valid & upd_c) ? c_new : carry_q;
	assign sign_d = (op_valid & upd_s) ? res[15] : sign_q;
	assign zero_d = (op_valid & upd_z) ? (res == 16'h0000) : zero_q;
	assign rng_d = (op_valid & upd_rng) ? rng_new : signed_range_flag_q;

	// State registers
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			acc_q <= ASL_ACC_RST;
			carry_q <= ASL_FLAG_RST;
			sign_q <= ASL_FLAG_RST;
			zero_q <= ASL_FLAG_RST;
			signed_range_flag_q <= ASL_FLAG_RST;
		end
		else
		begin
			acc_q <= acc_d;
			carry_q <= carry_d;
			sign_q <= sign_d;
			zero_q <= zero_d;
			signed_range_flag_q <= rng_d;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_rotl_wrap: assert property ( // [RL1]
		op_valid && op_sel == ASL_ROT_L |=>
		acc_q == {$past(acc_q[14:0]), $past(acc_q[15])}
		&& carry_q == $past(carry_q))
		else $error("rotate left wrong");
	a_rotlc_carry: assert property ( // [RL2]
		op_valid && op_sel == ASL_ROT_LC |=>
		acc_q[0] == $past(carry_q) && carry_q == $past(acc_q[15]))
		else $error("carry rotate left wrong");
	a_rotl_zero_kept: assert property ( // [RL3]
		op_valid && op_sel == ASL_ROT_L |=> $stable(zero_q))
		else $error("rotate left touched zero");
	a_rotrc_carry: assert property ( // [RL5]
		op_valid && op_sel == ASL_ROT_RC |=>
		acc_q[15] == $past(carry_q) && carry_q == $past(acc_q[0]))
		else $error("carry rotate right wrong");
	a_shl4_value: assert property ( // [RL7]
		op_valid && op_sel == ASL_SHL4 |=>
		acc_q == {$past(acc_q[11:0]), 4'h0} && carry_q == $past(acc_q[12]))
		else $error("four place left shift wrong");
	a_srl_top_zero: assert property ( // [RL8]
		op_valid && op_sel == ASL_SRL |=> !acc_q[15] && !sign_q)
		else $error("logical right shift top not zero");
	a_shra_sign: assert property ( // [RL12]
		op_valid && (op_sel == ASL_SHRA1 || op_sel == ASL_SHRA4) |=>
		$stable(sign_q) && acc_q[15] == $past(acc_q[15]))
		else $error("arithmetic right shift sign wrong");
	a_shra2_carry: assert property ( // [RL11]
		op_valid && op_sel == ASL_SHRA2 |=> carry_q == $past(acc_q[1]))
		else $error("two place right shift carry wrong");
	a_sub_value: assert property ( // [RL13]
		op_valid && op_sel == ASL_SUB |=>
		acc_q == $past(acc_q) - $past(src_word)
		&& zero_q == (acc_q == 16'h0000))
		else $error("subtract result wrong");
	a_bswap_flags: assert property ( // [RL17]
		op_valid && op_sel == ASL_BSWAP |=>
		acc_q == {$past(acc_q[7:0]), $past(acc_q[15:8])}
		&& $stable(carry_q) && $stable(zero_q))
		else $error("byte swap wrong");
	a_xorc_only: assert property ( // [RL20]
		op_valid && op_sel == ASL_XORC |=>
		$stable(sign_q) && $stable(zero_q) && $stable(signed_range_flag_q)
		&& ($past(acc_load) || $stable(acc_q)))
		else $error("carry xor changed other state");

	c_sub_borrow: cover property (op_valid && op_sel == ASL_SUBC && carry_q);
	c_range: cover property (op_valid && op_sel == ASL_SUB ##1
		signed_range_flag_q);
	c_rot_rc: cover property (op_valid && op_sel == ASL_ROT_RC);
	c_nswap: cover property (op_valid && op_sel == ASL_NSWAP);

endmodule

// *** test/tb_accumulator_shift_logic_unit.sv ***
`timescale 1ns/1ns
module tb_accumulator_shift_logic_unit
	import asl_pkg::*;
;
	// One table row: m[0] preloads a first, m[1] marks a byte source
	typedef struct packed {
		logic [1:0] m;
		logic [15:0] a;
		asl_op_t o;
		logic [15:0] s;
		logic [15:0] e;
		logic [3:0] f;
	} asl_row_t;

	logic mclk;
	logic srst;
	logic op_valid;
	asl_op_t op_sel;
	logic [3:0] bit_sel;
	logic [15:0] src_data;
	logic src_is_byte;
	logic [7:0] high_byte_prefix_reg;
	logic acc_load;
	logic [15:0] acc_load_data;
	logic [15:0] acc_q;
	logic carry_q;
	logic sign_q;
	logic zero_q;
	logic signed_range_flag_q;
	int mismatches;
	int tests_run;
	int cycles;
	logic [19:0] seen;

	// Flags packed as carry, sign, zero, overflow; rows run as one chain
	asl_row_t rows [34] = '{
		'{2'h1, 16'h2345, ASL_SUB, 16'h1250, 16'h10f5, 4'h0},
		'{2'h0, 16'h0, ASL_SUB, 16'h1250, 16'hfea5, 4'hc},
		'{2'h0, 16'h0, ASL_SUB, 16'h7fff, 16'h7ea6, 4'h1},
		'{2'h1, 16'h2345, ASL_XORC, 16'h0002, 16'h2345, 4'h9},
		'{2'h0, 16'h0, ASL_SUBC, 16'h1250, 16'h10f4, 4'h0},
		'{2'h0, 16'h0, ASL_SUBC, 16'h1250, 16'hfea4, 4'hc},
		'{2'h1, 16'ha345, ASL_ROT_LC, 16'h0, 16'h468b, 4'h8},
		'{2'h0, 16'h0, ASL_ROT_LC, 16'h0, 16'h8d17, 4'h4},
		'{2'h1, 16'ha345, ASL_ROT_L, 16'h0, 16'h468b, 4'h0},
		'{2'h0, 16'h0, ASL_ROT_L, 16'h0, 16'h8d16, 4'h4},
		'{2'h1, 16'ha345, ASL_XORC, 16'h0000, 16'ha345, 4'hc},
		'{2'h0, 16'h0, ASL_ROT_RC, 16'h0, 16'hd1a2, 4'hc},
		'{2'h0, 16'h0, ASL_ROT_RC, 16'h0, 16'he8d1, 4'h4},
		'{2'h1, 16'ha345, ASL_ROT_R, 16'h0, 16'hd1a2, 4'h4},
		'{2'h0, 16'h0, ASL_ROT_R, 16'h0, 16'h68d1, 4'h0},
		'{2'h1, 16'ha345, ASL_SRL, 16'h0, 16'h51a2, 4'h8},
		'{2'h0, 16'h0, ASL_SRL, 16'h0, 16'h28d1, 4'h0},
		'{2'h1, 16'he345, ASL_SHL1, 16'h0, 16'hc68a, 4'hc},
		'{2'h0, 16'h0, ASL_SHL1, 16'h0, 16'h8d14, 4'hc},
		'{2'h1, 16'he345, ASL_SHL2, 16'h0, 16'h8d14, 4'hc},
		'{2'h1, 16'he345, ASL_SHL4, 16'h0, 16'h3450, 4'h0},
		'{2'h1, 16'h0003, ASL_SHRA1, 16'h0, 16'h0001, 4'h8},
		'{2'h0, 16'h0, ASL_SHRA1, 16'h0, 16'h0000, 4'ha},
		'{2'h1, 16'h0003, ASL_SHRA2, 16'h0, 16'h0000, 4'ha},
		'{2'h1, 16'h9878, ASL_SHRA4, 16'h0, 16'hf987, 4'h8},
		'{2'h0, 16'h0, ASL_SHRA4, 16'h0, 16'hff98, 4'h0},
		'{2'h1, 16'h0080, ASL_BSWAP, 16'h0, 16'h8000, 4'h4},
		'{2'h0, 16'h0, ASL_NSWAP, 16'h0, 16'h0800, 4'h0},
		'{2'h1, 16'h2345, ASL_XOR, 16'h0f0f, 16'h2c4a, 4'h0},
		'{2'h2, 16'h0, ASL_XOR, 16'hff33, 16'h3d79, 4'h0},
		'{2'h0, 16'h0, ASL_XOR, 16'h3d79, 16'h0000, 4'h2},
		'{2'h0, 16'h0, ASL_NOP, 16'hffff, 16'h0000, 4'h2},
		'{2'h1, 16'h8000, ASL_XORC, 16'h000f, 16'h8000, 4'ha},
		'{2'h1, 16'h8000, ASL_SUB, 16'h0001, 16'h7fff, 4'h1}
	};

	asl_unit DUT (
		.mclk(mclk),
		.srst(srst),
		.op_valid(op_valid),
		.op_sel(op_sel),
		.bit_sel(bit_sel),
		.src_data(src_data),
		.src_is_byte(src_is_byte),
		.high_byte_prefix_reg(high_byte_prefix_reg),
		.acc_load(acc_load),
		.acc_load_data(acc_load_data),
		.acc_q(acc_q),
		.carry_q(carry_q),
		.sign_q(sign_q),
		.zero_q(zero_q),
		.signed_range_flag_q(signed_range_flag_q)
	);

	assign seen = {acc_q, carry_q, sign_q, zero_q, signed_range_flag_q};

	// Free-running core clock, 4 ns period
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Optional preload cycle, then one op; called just after a rising edge
	task automatic run(input asl_row_t r);
		if (r.m[0])
		begin
			acc_load <= 1'b1;
			acc_load_data <= r.a;
			@(posedge mclk);
		end
		acc_load <= 1'b0;
		op_valid <= 1'b1;
		op_sel <= r.o;
		src_data <= r.s;
		bit_sel <= r.s[3:0];
		src_is_byte <= r.m[1];
		@(posedge mclk);
		op_valid <= 1'b0;
	endtask

	// Hang guard: the whole run needs about a hundred cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			close_out();
		end
	end

	initial
	begin
		srst = 1'b1;
		op_valid = 1'b0;
		op_sel = ASL_NOP;
		bit_sel = 4'h0;
		src_data = 16'h0;
		src_is_byte = 1'b0;
		high_byte_prefix_reg = 8'h11;
		acc_load = 1'b0;
		acc_load_data = 16'h0;
		mismatches = 0;
		tests_run = 0;
		cycles = 0;
		repeat (5) @(posedge mclk);
		#1;
		check(seen, 20'h0);
		@(posedge mclk);
		srst <= 1'b0;
		foreach (rows[i])
		begin
			@(posedge mclk);
			run(rows[i]);
			#1;
			check(seen, {rows[i].e, rows[i].f});
		end
		// Op and load in one cycle: the op must win, load is dropped
		@(posedge mclk);
		acc_load <= 1'b1;
		acc_load_data <= 16'h1234;
		op_valid <= 1'b1;
		op_sel <= ASL_ROT_L;
		@(posedge mclk);
		acc_load <= 1'b0;
		op_valid <= 1'b0;
		#1;
		check(seen, {16'hfffe, 4'h5});
		// Reset in mid-run clears everything at the next edge
		@(posedge mclk);
		srst <= 1'b1;
		@(posedge mclk);
		srst <= 1'b0;
		#1;
		check(seen, 20'h0);
		close_out();
	end
endmodule
